// >>> src/pio_pkg.sv
// Shared constants, types and register map of the programmable I/O ports
package pio_pkg;
  localparam int NUM_PORTS = 3;
  localparam int PORT_B = 0;
  localparam int PORT_C = 1;
  localparam int PORT_D = 2;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int WIDE_PINS = 8;
  localparam int NARROW_PINS = 3;
  localparam int CELL_GROUP = 4;

  localparam logic [DATA_W-1:0] WIDE_MASK = 8'hFF;
  localparam logic [DATA_W-1:0] NARROW_MASK = 8'h07;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // Register offsets inside one port
  localparam logic [ADDR_W-1:0] OFF_DATA_IN = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DATA_OUT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIR = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_DRIVE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_INCELL = 8'h0A;
  localparam logic [ADDR_W-1:0] OFF_OUTCELL = 8'h0C;
  // Port offsets from the block base
  localparam logic [ADDR_W-1:0] PORT_OFF_B = 8'h00;
  localparam logic [ADDR_W-1:0] PORT_OFF_C = 8'h01;
  localparam logic [ADDR_W-1:0] PORT_OFF_D = 8'h10;
  localparam logic [ADDR_W-1:0] BASE_LIMIT = 8'hE0;

  // Pins whose drive bit selects open drain; the rest select fast slew
  localparam logic [WIDE_PINS-1:0] OD_MASK_B = 8'hF0;
  localparam logic [WIDE_PINS-1:0] OD_MASK_C = 8'hFF;
  localparam logic [NARROW_PINS-1:0] OD_MASK_D = 3'h0;

  typedef enum logic [1:0] {
    PIO_SRC_DATA_OUT,
    PIO_SRC_LOGIC_CELL,
    PIO_SRC_EXT_SELECT
  } pio_src_e;

  typedef enum logic [1:0] {
    PIO_IN_PASS,
    PIO_IN_LATCH,
    PIO_IN_REG
  } pio_incell_e;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pio_bus_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] out_value;
    logic [DATA_W-1:0] dir;
    logic [DATA_W-1:0] drive;
  } pio_port_regs_s;
endpackage : pio_pkg

// >>> src/pio_input_cell.sv
// Input cell group: pass, transparent latch or edge register per pin
module pio_input_cell import pio_pkg::*; #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input pio_incell_e mode [WIDTH],
  input wire logic pt_clock,
  input wire logic [WIDTH-1:0] pin_level,
  output logic [WIDTH-1:0] cell_out
);
  logic pt_prev;
  logic [WIDTH-1:0] held;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pt_prev <= 1'b0;
    end else begin
      pt_prev <= pt_clock;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      held <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (mode[i] == PIO_IN_REG && pt_clock && !pt_prev) begin
          held[i] <= pin_level[i];
        end else if (mode[i] == PIO_IN_LATCH && pt_clock) begin
          held[i] <= pin_level[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      case (mode[i])
        PIO_IN_LATCH: cell_out[i] = pt_clock ? pin_level[i] : held[i];
        PIO_IN_REG: cell_out[i] = held[i];
        default: cell_out[i] = pin_level[i];
      endcase
    end
  end
endmodule : pio_input_cell

// >>> src/pio_pin_driver.sv
// Output multiplexer, driver enable and drive style for one port
module pio_pin_driver import pio_pkg::*; #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] OD_MASK = '0,
  parameter bit USE_OE_TERM = 1'b1,
  parameter bit HAS_EXT = 1'b0
) (
  input pio_src_e src_sel [WIDTH],
  input wire logic [WIDTH-1:0] data_out,
  input wire logic [WIDTH-1:0] logic_cell,
  input wire logic [WIDTH-1:0] ext_select,
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] drive,
  input wire logic [WIDTH-1:0] oe_term,
  input wire logic [WIDTH-1:0] oe_term_defined,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] fast_slew
);
  logic [WIDTH-1:0] value;
  logic [WIDTH-1:0] enable;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      case (src_sel[i])
        PIO_SRC_LOGIC_CELL: value[i] = logic_cell[i];
        PIO_SRC_EXT_SELECT: value[i] = HAS_EXT ? ext_select[i] : data_out[i];
        default: value[i] = data_out[i];
      endcase
      // Undefined term leaves the direction bit in sole control
      enable[i] = dir[i] | (USE_OE_TERM & oe_term_defined[i] & oe_term[i]);
      if (OD_MASK[i] && drive[i]) begin
        pin_out[i] = 1'b0;
        pin_oe[i] = enable[i] & ~value[i];
      end else begin
        pin_out[i] = value[i];
        pin_oe[i] = enable[i];
      end
      fast_slew[i] = ~OD_MASK[i] & drive[i];
    end
  end
endmodule : pio_pin_driver

// >>> src/pio_ports.sv
// Top of the programmable I/O ports: host registers, readback and pins
module pio_ports import pio_pkg::*; #(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 8'h00,
  parameter logic [WIDE_PINS-1:0] JTAG_PIN_MASK = 8'h0F
) (
  input wire logic clock,
  input wire logic rst_b,
  input pio_bus_req_s host_req,
  output logic [DATA_W-1:0] host_rdata,
  output logic host_rdata_oe,
  input wire logic [WIDE_PINS-1:0] pin_b_in,
  output logic [WIDE_PINS-1:0] pin_b_out,
  output logic [WIDE_PINS-1:0] pin_b_oe,
  output logic [WIDE_PINS-1:0] pin_b_fast_slew,
  input wire logic [WIDE_PINS-1:0] pin_c_in,
  output logic [WIDE_PINS-1:0] pin_c_out,
  output logic [WIDE_PINS-1:0] pin_c_oe,
  output logic [WIDE_PINS-1:0] pin_c_fast_slew,
  input wire logic [NARROW_PINS-1:0] pin_d_in,
  output logic [NARROW_PINS-1:0] pin_d_out,
  output logic [NARROW_PINS-1:0] pin_d_oe,
  output logic [NARROW_PINS-1:0] pin_d_fast_slew,
  input pio_src_e src_sel_b [WIDE_PINS],
  input pio_src_e src_sel_c [WIDE_PINS],
  input pio_src_e src_sel_d [NARROW_PINS],
  input wire logic [WIDE_PINS-1:0] oe_term_b,
  input wire logic [WIDE_PINS-1:0] oe_term_defined_b,
  input wire logic [WIDE_PINS-1:0] oe_term_c,
  input wire logic [WIDE_PINS-1:0] oe_term_defined_c,
  input pio_incell_e input_logic_cell_mode_b [WIDE_PINS],
  input pio_incell_e input_logic_cell_mode_c [WIDE_PINS],
  input wire logic [1:0] input_logic_cell_clock_b,
  input wire logic [1:0] input_logic_cell_clock_c,
  input wire logic [WIDE_PINS-1:0] output_cell_group_one,
  input wire logic [WIDE_PINS-1:0] output_cell_group_two,
  input wire logic [NARROW_PINS-1:0] external_select_outputs,
  output logic [WIDE_PINS-1:0] logic_in_b,
  output logic [WIDE_PINS-1:0] logic_in_c,
  output logic [NARROW_PINS-1:0] logic_in_d,
  input wire logic jtag_enable,
  input wire logic [WIDE_PINS-1:0] jtag_pin_out,
  input wire logic [WIDE_PINS-1:0] jtag_pin_oe,
  output logic [WIDE_PINS-1:0] jtag_pin_in
);
  generate
    if (BASE_ADDR > BASE_LIMIT) begin : g_bad_base
      $error("BASE_ADDR leaves no room for the port registers");
    end
    // Refuse shapes that the decode and pin maps cannot serve
    if (JTAG_PIN_MASK == '0) begin : g_no_jtag
      $error("JTAG_PIN_MASK selects no programming pins");
    end
    if (WIDE_PINS != DATA_W) begin : g_bad_wide
      $error("Eight-pin ports must match the register width");
    end
    if (NARROW_PINS >= DATA_W) begin : g_bad_narrow
      $error("Three-pin port must be narrower than the registers");
    end
    if ((WIDE_PINS % CELL_GROUP) != 0) begin : g_bad_cells
      $error("Cell groups must divide the eight-pin ports evenly");
    end
    if ((WIDE_PINS / CELL_GROUP) != $bits(input_logic_cell_clock_b)) begin : g_bad_clocks
      $error("One cell clock is needed for each cell group");
    end
    if (PORT_OFF_C + OFF_OUTCELL >= PORT_OFF_D) begin : g_bad_windows
      $error("Port C registers run into the port D window");
    end
  endgenerate

  pio_port_regs_s port_regs [NUM_PORTS];
  logic [DATA_W-1:0] port_output_value [NUM_PORTS];
  logic [DATA_W-1:0] port_pin_direction [NUM_PORTS];
  logic [DATA_W-1:0] port_drive_style [NUM_PORTS];
  logic wr_prev;
  logic [ADDR_W-1:0] addr_held;
  logic [DATA_W-1:0] data_held;
  logic write_commit;
  logic bus_wr;
  logic bus_rd;
  logic [DATA_W-1:0] next_host_rdata;
  logic [DATA_W-1:0] pin_level [NUM_PORTS];
  logic [DATA_W-1:0] cell_level [NUM_PORTS];
  logic [DATA_W-1:0] outcell_level [NUM_PORTS];
  logic [WIDE_PINS-1:0] drv_c_out;
  logic [WIDE_PINS-1:0] drv_c_oe;

  function automatic logic [DATA_W-1:0] port_mask(input int p);
    return (p == PORT_D) ? NARROW_MASK : WIDE_MASK;
  endfunction : port_mask

  function automatic logic [ADDR_W-1:0] reg_addr(input int p, input logic [ADDR_W-1:0] off);
    logic [ADDR_W-1:0] port_off;
    if (p == PORT_B) begin
      port_off = PORT_OFF_B;
    end else if (p == PORT_C) begin
      port_off = PORT_OFF_C;
    end else begin
      port_off = PORT_OFF_D;
    end
    return ADDR_W'(BASE_ADDR + port_off + off);
  endfunction : reg_addr

  assign bus_wr = host_req.cs & host_req.wr;
  assign bus_rd = host_req.cs & host_req.rd;

  // Address and data held while the strobe is up, used at its fall
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_prev <= 1'b0;
      addr_held <= '0;
      data_held <= '0;
    end else begin
      wr_prev <= bus_wr;
      if (bus_wr) begin
        addr_held <= host_req.addr;
        data_held <= host_req.wdata;
      end
    end
  end

  assign write_commit = wr_prev & ~bus_wr;

  // Data-out registers, loaded at the strobe's trailing edge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_output_value[p] <= REG_RESET;
      end
    end else if (write_commit) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr_held == reg_addr(p, OFF_DATA_OUT)) begin
          port_output_value[p] <= data_held & port_mask(p);
        end
      end
    end
  end

  // Direction registers; every direction bit resets to input, though enable terms can still drive port B and C pins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_pin_direction[p] <= REG_RESET;
      end
    end else if (write_commit) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr_held == reg_addr(p, OFF_DIR)) begin
          port_pin_direction[p] <= data_held & port_mask(p);
        end
      end
    end
  end

  // Drive style registers: open drain or fast slew per pin
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        port_drive_style[p] <= REG_RESET;
      end
    end else if (write_commit) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (addr_held == reg_addr(p, OFF_DRIVE)) begin
          port_drive_style[p] <= data_held & port_mask(p);
        end
      end
    end
  end

  // Register bundle per port for the readback and the pin drivers
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_regs[p].out_value = port_output_value[p];
      port_regs[p].dir = port_pin_direction[p];
      port_regs[p].drive = port_drive_style[p];
    end
  end

  // Sources seen by the readback buffer, zero-extended
  always_comb begin
    pin_level[PORT_B] = pin_b_in;
    pin_level[PORT_C] = pin_c_in;
    pin_level[PORT_D] = {{(DATA_W - NARROW_PINS){1'b0}}, pin_d_in};
    cell_level[PORT_B] = logic_in_b;
    cell_level[PORT_C] = logic_in_c;
    cell_level[PORT_D] = {{(DATA_W - NARROW_PINS){1'b0}}, logic_in_d};
    outcell_level[PORT_B] = output_cell_group_one;
    outcell_level[PORT_C] = output_cell_group_two;
    outcell_level[PORT_D] = {{(DATA_W - NARROW_PINS){1'b0}}, external_select_outputs};
  end

  always_comb begin
    next_host_rdata = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (host_req.addr == reg_addr(p, OFF_DATA_IN)) begin
        next_host_rdata = pin_level[p];
      end else if (host_req.addr == reg_addr(p, OFF_DATA_OUT)) begin
        next_host_rdata = port_regs[p].out_value;
      end else if (host_req.addr == reg_addr(p, OFF_DIR)) begin
        next_host_rdata = port_regs[p].dir;
      end else if (host_req.addr == reg_addr(p, OFF_DRIVE)) begin
        next_host_rdata = port_regs[p].drive;
      end else if (host_req.addr == reg_addr(p, OFF_INCELL)) begin
        next_host_rdata = cell_level[p];
      end else if (host_req.addr == reg_addr(p, OFF_OUTCELL)) begin
        next_host_rdata = outcell_level[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      host_rdata <= '0;
    end else if (bus_rd) begin
      host_rdata <= next_host_rdata;
    end else begin
      host_rdata <= '0;
    end
  end

  // Only one source reaches the bus, and only during a read
  assign host_rdata_oe = bus_rd;

  // Input cells, four pins to each clocking product term
  generate
    for (genvar g = 0; g < WIDE_PINS / CELL_GROUP; g++) begin : g_cells
      pio_input_cell #(
        .WIDTH(CELL_GROUP)
      ) u_cell_b (
        .clock(clock),
        .rst_b(rst_b),
        .mode(input_logic_cell_mode_b[g*CELL_GROUP +: CELL_GROUP]),
        .pt_clock(input_logic_cell_clock_b[g]),
        .pin_level(pin_b_in[g*CELL_GROUP +: CELL_GROUP]),
        .cell_out(logic_in_b[g*CELL_GROUP +: CELL_GROUP])
      );
      pio_input_cell #(
        .WIDTH(CELL_GROUP)
      ) u_cell_c (
        .clock(clock),
        .rst_b(rst_b),
        .mode(input_logic_cell_mode_c[g*CELL_GROUP +: CELL_GROUP]),
        .pt_clock(input_logic_cell_clock_c[g]),
        .pin_level(pin_c_in[g*CELL_GROUP +: CELL_GROUP]),
        .cell_out(logic_in_c[g*CELL_GROUP +: CELL_GROUP])
      );
    end
  endgenerate

  assign logic_in_d = pin_d_in;

  pio_pin_driver #(
    .WIDTH(WIDE_PINS),
    .OD_MASK(OD_MASK_B),
    .USE_OE_TERM(1'b1),
    .HAS_EXT(1'b0)
  ) u_drv_b (
    .src_sel(src_sel_b),
    .data_out(port_regs[PORT_B].out_value),
    .logic_cell(output_cell_group_one),
    .ext_select('0),
    .dir(port_regs[PORT_B].dir),
    .drive(port_regs[PORT_B].drive),
    .oe_term(oe_term_b),
    .oe_term_defined(oe_term_defined_b),
    .pin_out(pin_b_out),
    .pin_oe(pin_b_oe),
    .fast_slew(pin_b_fast_slew)
  );

  pio_pin_driver #(
    .WIDTH(WIDE_PINS),
    .OD_MASK(OD_MASK_C),
    .USE_OE_TERM(1'b1),
    .HAS_EXT(1'b0)
  ) u_drv_c (
    .src_sel(src_sel_c),
    .data_out(port_regs[PORT_C].out_value),
    .logic_cell(output_cell_group_two),
    .ext_select('0),
    .dir(port_regs[PORT_C].dir),
    .drive(port_regs[PORT_C].drive),
    .oe_term(oe_term_c),
    .oe_term_defined(oe_term_defined_c),
    .pin_out(drv_c_out),
    .pin_oe(drv_c_oe),
    .fast_slew(pin_c_fast_slew)
  );

  pio_pin_driver #(
    .WIDTH(NARROW_PINS),
    .OD_MASK(OD_MASK_D),
    .USE_OE_TERM(1'b0),
    .HAS_EXT(1'b1)
  ) u_drv_d (
    .src_sel(src_sel_d),
    .data_out(port_regs[PORT_D].out_value[NARROW_PINS-1:0]),
    .logic_cell('0),
    .ext_select(external_select_outputs),
    .dir(port_regs[PORT_D].dir[NARROW_PINS-1:0]),
    .drive(port_regs[PORT_D].drive[NARROW_PINS-1:0]),
    .oe_term('0),
    .oe_term_defined('0),
    .pin_out(pin_d_out),
    .pin_oe(pin_d_oe),
    .fast_slew(pin_d_fast_slew)
  );

  // Programming pins take over the shared port C pins while enabled
  always_comb begin
    for (int i = 0; i < WIDE_PINS; i++) begin
      if (jtag_enable && JTAG_PIN_MASK[i]) begin
        pin_c_out[i] = jtag_pin_out[i];
        pin_c_oe[i] = jtag_pin_oe[i];
      end else begin
        pin_c_out[i] = drv_c_out[i];
        pin_c_oe[i] = drv_c_oe[i];
      end
    end
  end

  assign jtag_pin_in = pin_c_in & JTAG_PIN_MASK;
endmodule : pio_ports

// >>> verif/pio_ports_sva.sv
// Assertion checker bound to the programmable I/O ports top
module pio_ports_chk import pio_pkg::*; #(
  parameter logic [WIDE_PINS-1:0] JTAG_PIN_MASK = 8'h0F
) (
  input wire logic clock,
  input wire logic rst_b,
  input pio_bus_req_s host_req,
  input wire logic [DATA_W-1:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic [WIDE_PINS-1:0] pin_b_in,
  input wire logic [WIDE_PINS-1:0] pin_b_out,
  input wire logic [WIDE_PINS-1:0] pin_b_oe,
  input wire logic [WIDE_PINS-1:0] pin_c_in,
  input wire logic [NARROW_PINS-1:0] pin_d_in,
  input wire logic [NARROW_PINS-1:0] pin_d_out,
  input wire logic [NARROW_PINS-1:0] pin_d_oe,
  input wire logic [NARROW_PINS-1:0] pin_d_fast_slew,
  input pio_src_e src_sel_b [WIDE_PINS],
  input pio_src_e src_sel_d [NARROW_PINS],
  input wire logic [WIDE_PINS-1:0] oe_term_b,
  input wire logic [WIDE_PINS-1:0] oe_term_defined_b,
  input pio_incell_e input_logic_cell_mode_b [WIDE_PINS],
  input wire logic [1:0] input_logic_cell_clock_b,
  input wire logic [WIDE_PINS-1:0] output_cell_group_one,
  input wire logic [NARROW_PINS-1:0] external_select_outputs,
  input wire logic [WIDE_PINS-1:0] logic_in_b,
  input wire logic [NARROW_PINS-1:0] logic_in_d,
  input wire logic [WIDE_PINS-1:0] jtag_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  read_enable_a: assert property (host_rdata_oe == (host_req.cs && host_req.rd))
    else $error("read enable mismatch");
  read_idle_a: assert property (!(host_req.cs && host_req.rd) |=> host_rdata == 8'h00)
    else $error("read data not cleared");
  enable_or_a: assert property (((oe_term_b & oe_term_defined_b & ~pin_b_oe) & 8'h0F) == 8'h00)
    else $error("enable term ignored");
  cell_drive_a: assert property (src_sel_b[0] == PIO_SRC_LOGIC_CELL && pin_b_oe[0]
    |-> pin_b_out[0] == output_cell_group_one[0]) else $error("cell output lost");
  ext_select_a: assert property (src_sel_d[0] == PIO_SRC_EXT_SELECT && pin_d_oe[0]
    |-> pin_d_out[0] == external_select_outputs[0]) else $error("select output lost");
  direct_input_a: assert property (logic_in_d == pin_d_in)
    else $error("port d input not direct");
  jtag_input_a: assert property (jtag_pin_in == (pin_c_in & JTAG_PIN_MASK))
    else $error("jtag input mismatch");
  pass_cell_a: assert property (input_logic_cell_mode_b[0] == PIO_IN_PASS
    |-> logic_in_b[0] == pin_b_in[0]) else $error("pass cell mismatch");
  reg_cell_a: assert property (input_logic_cell_mode_b[1] == PIO_IN_REG
    && $rose(input_logic_cell_clock_b[0]) |=> logic_in_b[1] == $past(pin_b_in[1]))
    else $error("register cell mismatch");
  strobe_commit_a: assert property ($changed(pin_d_fast_slew)
    |-> !$past(host_req.wr) && $past(host_req.wr, 2)) else $error("write not at strobe end");
endmodule : pio_ports_chk

bind pio_ports pio_ports_chk #(.JTAG_PIN_MASK(JTAG_PIN_MASK)) u_pio_ports_chk (
  .clock, .rst_b, .host_req, .host_rdata, .host_rdata_oe, .pin_b_in, .pin_b_out, .pin_b_oe,
  .pin_c_in, .pin_d_in, .pin_d_out, .pin_d_oe, .pin_d_fast_slew, .src_sel_b, .src_sel_d,
  .oe_term_b, .oe_term_defined_b, .input_logic_cell_mode_b, .input_logic_cell_clock_b,
  .output_cell_group_one, .external_select_outputs, .logic_in_b, .logic_in_d, .jtag_pin_in
);

// >>> verif/pio_pin_model.sv
// Far side of one port: an outside source meets the port driver
module pio_pin_model #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic [WIDTH-1:0] ext_level,
  output logic [WIDTH-1:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released pins follow the outside level
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pio_pin_model

// >>> verif/pio_ports_tb_top.sv
// Self-checking testbench of the programmable I/O ports
module pio_ports_tb_top import pio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 5000;
  localparam logic [7:0] PORTS [3] = '{PORT_OFF_B, PORT_OFF_C, PORT_OFF_D};
  localparam logic [7:0] REGS [3] = '{OFF_DATA_OUT, OFF_DIR, OFF_DRIVE};
  localparam logic [7:0] MASKS [3] = '{WIDE_MASK, WIDE_MASK, NARROW_MASK};
  logic clock, rst_b, host_rdata_oe, jtag_enable;
  pio_bus_req_s host_req;
  logic [7:0] host_rdata, pin_b_in, pin_b_out, pin_b_oe, pin_b_fast_slew, ext_b, ext_c;
  logic [7:0] pin_c_in, pin_c_out, pin_c_oe, pin_c_fast_slew, oe_term_b, oe_term_defined_b;
  logic [7:0] oe_term_c, oe_term_defined_c, output_cell_group_one, output_cell_group_two;
  logic [7:0] logic_in_b, logic_in_c, jtag_pin_out, jtag_pin_oe, jtag_pin_in;
  logic [2:0] pin_d_in, pin_d_out, pin_d_oe, pin_d_fast_slew, external_select_outputs;
  logic [2:0] logic_in_d, ext_d;
  logic [1:0] input_logic_cell_clock_b, input_logic_cell_clock_c;
  pio_src_e src_sel_b [8], src_sel_c [8], src_sel_d [3];
  pio_incell_e input_logic_cell_mode_b [8], input_logic_cell_mode_c [8];
  int num_errors = 0, total_checks = 0, cycles = 0;

  pio_ports u_pio_ports (.clock, .rst_b, .host_req, .host_rdata, .host_rdata_oe, .pin_b_in,
    .pin_b_out, .pin_b_oe, .pin_b_fast_slew, .pin_c_in, .pin_c_out, .pin_c_oe, .pin_c_fast_slew,
    .pin_d_in, .pin_d_out, .pin_d_oe, .pin_d_fast_slew, .src_sel_b, .src_sel_c, .src_sel_d,
    .oe_term_b, .oe_term_defined_b, .oe_term_c, .oe_term_defined_c, .input_logic_cell_mode_b,
    .input_logic_cell_mode_c, .input_logic_cell_clock_b, .input_logic_cell_clock_c,
    .output_cell_group_one, .output_cell_group_two, .external_select_outputs, .logic_in_b,
    .logic_in_c, .logic_in_d, .jtag_enable, .jtag_pin_out, .jtag_pin_oe, .jtag_pin_in);
  pio_pin_model #(.WIDTH(8)) u_pio_pin_model_b (.pin_out(pin_b_out), .pin_oe(pin_b_oe),
    .ext_level(ext_b), .pin_level(pin_b_in));
  pio_pin_model #(.WIDTH(8)) u_pio_pin_model_c (.pin_out(pin_c_out), .pin_oe(pin_c_oe),
    .ext_level(ext_c), .pin_level(pin_c_in));
  pio_pin_model #(.WIDTH(3)) u_pio_pin_model_d (.pin_out(pin_d_out), .pin_oe(pin_d_oe),
    .ext_level(ext_d), .pin_level(pin_d_in));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic conclude();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    host_req <= {1'b1, 1'b0, 1'b1, a, d};
    @(posedge clock);
    host_req <= '0;
    @(posedge clock);
    @(negedge clock);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    host_req <= {1'b1, 1'b1, 1'b0, a, 8'h00};
    @(posedge clock);
    host_req <= '0;
    @(negedge clock);
    chk(host_rdata, exp);
  endtask : rc

  task automatic t_regs();
    for (int p = 0; p < 3; p++) begin
      for (int r = 0; r < 3; r++) begin
        rc(PORTS[p] + REGS[r], REG_RESET);
        wr(PORTS[p] + REGS[r], 8'hDB);
        rc(PORTS[p] + REGS[r], 8'hDB & MASKS[p]);
        wr(PORTS[p] + REGS[r], 8'h00);
      end
    end
    wr(OFF_DATA_IN, 8'hFF);
    rc(OFF_DATA_IN, 8'h00);
    rc(8'hF0, 8'h00);
  endtask : t_regs

  task automatic t_incell();
    @(posedge clock);
    ext_b <= 8'h3C;
    input_logic_cell_mode_b <= '{default: PIO_IN_REG};
    @(posedge clock);
    input_logic_cell_clock_b <= 2'b11;
    @(posedge clock);
    input_logic_cell_clock_b <= 2'b00;
    ext_b <= 8'hC3;
    @(negedge clock);
    chk(logic_in_b, 8'h3C);
    @(posedge clock);
    input_logic_cell_mode_b <= '{default: PIO_IN_LATCH};
    input_logic_cell_clock_b <= 2'b11;
    @(negedge clock);
    chk(logic_in_b, 8'hC3);
    @(posedge clock);
    input_logic_cell_mode_b <= '{default: PIO_IN_PASS};
    input_logic_cell_clock_b <= 2'b00;
    ext_b <= 8'h3C;
    @(negedge clock);
    chk(logic_in_b, 8'h3C);
  endtask : t_incell

  task automatic t_mcu_oe();
    chk(pin_b_oe, 8'h00);
    wr(PORT_OFF_B + OFF_DIR, 8'h0F);
    wr(PORT_OFF_B + OFF_DATA_OUT, 8'hA5);
    chk(pin_b_oe, 8'h0F);
    chk(pin_b_out & 8'h0F, 8'h05);
    rc(PORT_OFF_B + OFF_DATA_IN, 8'h35);
    wr(PORT_OFF_D + OFF_DIR, 8'h07);
    wr(PORT_OFF_D + OFF_DATA_OUT, 8'h02);
    chk({5'h00, pin_d_out}, 8'h02);
    @(posedge clock);
    oe_term_b <= 8'h30;
    @(negedge clock);
    chk(pin_b_oe, 8'h0F);
    @(posedge clock);
    oe_term_defined_b <= 8'hFF;
    @(negedge clock);
    chk(pin_b_oe, 8'h3F);
    wr(PORT_OFF_B + OFF_DIR, 8'h00);
    chk(pin_b_oe, 8'h30);
    @(posedge clock);
    oe_term_b <= 8'h00;
    @(negedge clock);
    chk(pin_b_oe, 8'h00);
  endtask : t_mcu_oe

  task automatic t_jtag();
    @(posedge clock);
    jtag_enable <= 1'b1;
    jtag_pin_oe <= 8'h0F;
    jtag_pin_out <= 8'h0A;
    ext_c <= 8'h50;
    @(negedge clock);
    chk(pin_c_oe, 8'h0F);
    chk(pin_c_in, 8'h5A);
    chk(jtag_pin_in, 8'h0A);
    chk(logic_in_c, 8'h5A);
    rc(PORT_OFF_C + OFF_INCELL, 8'h5A);
    @(posedge clock);
    jtag_enable <= 1'b0;
  endtask : t_jtag

  task automatic t_logic_drive();
    @(posedge clock);
    src_sel_b <= '{default: PIO_SRC_LOGIC_CELL};
    src_sel_c <= '{default: PIO_SRC_LOGIC_CELL};
    src_sel_d <= '{default: PIO_SRC_EXT_SELECT};
    output_cell_group_one <= 8'h96;
    output_cell_group_two <= 8'h69;
    external_select_outputs <= 3'h5;
    // No pin here is a logic input, so outputs may be enabled
    wr(PORT_OFF_B + OFF_DIR, 8'hFF);
    wr(PORT_OFF_C + OFF_DIR, 8'hFF);
    chk(pin_b_out, 8'h96);
    chk(pin_c_out, 8'h69);
    chk({5'h00, pin_d_out}, 8'h05);
    wr(PORT_OFF_B + OFF_DRIVE, 8'hFF);
    wr(PORT_OFF_C + OFF_DRIVE, 8'hFF);
    wr(PORT_OFF_D + OFF_DRIVE, 8'h07);
    chk(pin_b_fast_slew, 8'h0F);
    chk(pin_c_fast_slew, 8'h00);
    chk({5'h00, pin_d_fast_slew}, 8'h07);
    chk(pin_c_oe, 8'h96);
    chk(pin_c_out, 8'h00);
    chk(pin_b_oe, 8'h6F);
    rc(PORT_OFF_B + OFF_OUTCELL, 8'h96);
    rc(PORT_OFF_D + OFF_OUTCELL, 8'h05);
  endtask : t_logic_drive

  initial begin
    rst_b = 1'b0;
    host_req = '0;
    jtag_enable = 1'b0;
    {ext_b, ext_c, ext_d, oe_term_b, oe_term_defined_b, oe_term_c, oe_term_defined_c} = '0;
    {output_cell_group_one, output_cell_group_two, external_select_outputs} = '0;
    {jtag_pin_out, jtag_pin_oe, input_logic_cell_clock_b, input_logic_cell_clock_c} = '0;
    src_sel_b = '{default: PIO_SRC_DATA_OUT};
    src_sel_c = '{default: PIO_SRC_DATA_OUT};
    src_sel_d = '{default: PIO_SRC_DATA_OUT};
    input_logic_cell_mode_b = '{default: PIO_IN_PASS};
    input_logic_cell_mode_c = '{default: PIO_IN_PASS};
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    t_regs();
    t_incell();
    t_mcu_oe();
    t_jtag();
    t_logic_drive();
    conclude();
  end
endmodule : pio_ports_tb_top
